// ---- src/slr_line_pacer.v ----
// sensor line readout: lane capture, line order check, fifo, paced line output
// Functional notes
// - rows read one at a time, 10-bit samples
// - next exposure ends as readout begins
// - 64 converters; 80 or 64 column grouping
// - lines emitted in sequential line order
// - each converter at 1/64 pixel rate
// - up to 32 parallel lvds lanes accepted; only the lowest valid lane's pixel is taken each cycle
// - adjustable output pixel clock rate
// - optional 1 us gap after each line
// - colour bayer mosaic starts with red
`include "slr_regs.vh"
module slr_line_pacer #(
  parameter PIX_W     = `SLR_PIX_W,
  parameter LANES     = `SLR_LANES,
  parameter FIFO_DEP  = `SLR_FIFO_DEPTH,
  parameter FIFO_AW   = 5,
  parameter LINE_W    = 16,
  parameter GAP_CYC   = `SLR_GAP_CYC
) (
  input  wire                   clk_sys_in,
  input  wire                   sys_rst_in,
  input  wire [LANES*PIX_W-1:0] lane_data_in,
  input  wire [LANES-1:0]       lane_valid_in,
  input  wire                   row_start_in,
  input  wire [LINE_W-1:0]      row_index_in,
  input  wire                   frame_start_in,
  input  wire [LINE_W-1:0]      row_width_in,
  input  wire [LINE_W-1:0]      rows_per_frame_in,
  input  wire                   large_variant_in,
  input  wire                   colour_in,
  input  wire                   row_gap_en_in,
  input  wire [7:0]             pix_div_in,
  input  wire                   exp_armed_in,
  output reg                    lane_ready_out,
  output reg  [PIX_W-1:0]       pix_data_out,
  output reg                    pix_valid_out,
  output reg                    pix_clk_en_out,
  output reg                    line_valid_out,
  output reg                    frame_valid_out,
  output reg  [1:0]             bayer_phase_out,
  output reg                    exposure_on_out,
  output reg                    adc_strobe_out,
  output reg  [6:0]             col_group_out,
  output reg                    order_err_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LINE = 2'h1;
  localparam ST_GAP  = 2'h2;
  localparam LW      = LINE_W;
  // lane fan-in: pick the lowest valid lane each cycle
  function [5:0] first_lane;
    input [LANES-1:0] v;
    integer k;
    begin
      first_lane = 6'h00;
      for (k = LANES - 1; k >= 0; k = k - 1)
        if (v[k])
          first_lane = k[5:0];
    end
  endfunction
  reg [PIX_W-1:0]  lane_pick;
  wire             in_any = |lane_valid_in;
  integer          j;
  always @*
  begin
    lane_pick = {PIX_W{1'b0}};
    for (j = 0; j < LANES; j = j + 1)
      if (first_lane(lane_valid_in) == j[5:0])
        lane_pick = lane_data_in[j*PIX_W +: PIX_W];
  end
  // order check: rows whose index is not the expected one are dropped and flagged,
  // the sensor side is expected to present rows in order already resequenced
  reg [LW-1:0]     exp_row_q;
  reg              row_ok_q;
  wire             fifo_wr_rdy;
  wire [PIX_W-1:0] fifo_rd_data;
  wire             fifo_rd_valid;
  reg              fifo_rd_rdy;
  always @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      exp_row_q      <= {LW{1'b0}};
      row_ok_q       <= 1'b0;
      order_err_out  <= 1'b0;
      lane_ready_out <= 1'b0;
    end
    else
    begin
      lane_ready_out <= fifo_wr_rdy;
      if (frame_start_in)
      begin
        exp_row_q     <= {LW{1'b0}};
        order_err_out <= 1'b0;
      end
      else if (row_start_in)
      begin
        row_ok_q <= (row_index_in == exp_row_q);
        if (row_index_in == exp_row_q)
          exp_row_q <= exp_row_q + 1'b1;
        else
          order_err_out <= 1'b1;
      end
    end
  end
  slr_fifo #(
    .WIDTH (PIX_W),
    .DEPTH (FIFO_DEP),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .wr_data_in   (lane_pick),
    .wr_valid_in  (in_any && row_ok_q),
    .wr_ready_out (fifo_wr_rdy),
    .rd_data_out  (fifo_rd_data),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (fifo_rd_rdy)
  );
  // output pixel rate: one enable every pix_div_in+1 cycles
  reg [7:0]  div_q;
  wire       tick = (div_q == 8'h00);
  always @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      div_q <= 8'h00;
    else
      div_q <= tick ? pix_div_in : div_q - 8'h01;
  end
  // converter strobe: each of the 64 converters fires once per 64 pixels
  reg [5:0] adc_q;
  always @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      adc_q          <= 6'h00;
      adc_strobe_out <= 1'b0;
      col_group_out  <= 7'h00;
    end
    else
    begin
      col_group_out <= large_variant_in ? `SLR_GRP_LARGE : `SLR_GRP_SMALL;
      if (in_any && row_ok_q)
        adc_q <= adc_q + 6'h01;
      adc_strobe_out <= in_any && row_ok_q && (adc_q == 6'h00);
    end
  end
  // pacing state machine
  reg [1:0]     st_q;
  reg [LW-1:0]  col_q;
  reg [LW-1:0]  line_q;
  reg [15:0]    gap_q;
  wire          fire = (st_q == ST_LINE) && tick && fifo_rd_valid;
  always @*
  begin
    fifo_rd_rdy = fire;
  end
  always @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      st_q            <= ST_IDLE;
      col_q           <= {LW{1'b0}};
      line_q          <= {LW{1'b0}};
      gap_q           <= 16'h0000;
      pix_data_out    <= {PIX_W{1'b0}};
      pix_valid_out   <= 1'b0;
      pix_clk_en_out  <= 1'b0;
      line_valid_out  <= 1'b0;
      frame_valid_out <= 1'b0;
      bayer_phase_out <= `SLR_BAYER_R;
      exposure_on_out <= 1'b0;
    end
    else
    begin
      pix_clk_en_out <= tick;
      pix_valid_out  <= fire;
      // follows the state one cycle late so the last pixel still sits inside its line
      line_valid_out <= (st_q == ST_LINE);
      if (fire)
        pix_data_out <= fifo_rd_data;
      // exposure of the next frame runs during readout, ending at frame start
      if (frame_start_in)
        exposure_on_out <= 1'b0;
      else if (frame_valid_out && exp_armed_in)
        exposure_on_out <= 1'b1;
      case (st_q)
        ST_IDLE:
        begin
          if (frame_start_in)
          begin
            frame_valid_out <= 1'b1;
            line_q          <= {LW{1'b0}};
          end
          if ((frame_valid_out || frame_start_in) && fifo_rd_valid)
          begin
            st_q           <= ST_LINE;
            col_q          <= {LW{1'b0}};
          end
        end
        ST_LINE:
        begin
          if (fire)
          begin
            if (colour_in)
              bayer_phase_out <= {line_q[0], col_q[0]};
            else
              bayer_phase_out <= `SLR_BAYER_R;
            if (col_q == row_width_in - 1'b1)
            begin
              line_q         <= line_q + 1'b1;
              gap_q          <= GAP_CYC[15:0];
              st_q           <= row_gap_en_in ? ST_GAP : ST_IDLE;
              if (line_q == rows_per_frame_in - 1'b1)
                frame_valid_out <= 1'b0;
            end
            else
              col_q <= col_q + 1'b1;
          end
        end
        ST_GAP:
        begin
          gap_q <= gap_q - 16'h0001;
          if (gap_q == 16'h0001)
            st_q <= ST_IDLE;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // slr_line_pacer

// ---- src/slr_regs.vh ----
// constants for the sensor line readout pacing block
`ifndef SLR_REGS_VH
`define SLR_REGS_VH
`define SLR_PIX_W          10
`define SLR_LANES          32
`define SLR_ADC_NUM        64
`define SLR_GRP_LARGE      7'h50
`define SLR_GRP_SMALL      7'h40
`define SLR_FIFO_DEPTH     32
`define SLR_CLK_MHZ        200
`define SLR_GAP_US         1
`define SLR_GAP_CYC        (`SLR_GAP_US * `SLR_CLK_MHZ)
`define SLR_BAYER_R        2'h0
`define SLR_BAYER_GR       2'h1
`define SLR_BAYER_GB       2'h2
`define SLR_BAYER_B        2'h3
`endif

// ---- src/slr_fifo.v ----
// synchronous valid/ready fifo with registered read data
module slr_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_sys_in,
  input  wire             sys_rst_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output reg  [WIDTH-1:0] rd_data_out,
  output reg              rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  wire            full  = (cnt_q == DEPTH[AW:0]);
  wire            empty = (cnt_q == {(AW+1){1'b0}});
  wire            wr_en = wr_valid_in && !full;
  // output register refills whenever it is empty or being taken
  wire            rd_en = !empty && (!rd_valid_out || rd_ready_in);
  assign wr_ready_out = !full;
  always @(posedge clk_sys_in)
  begin
    if (wr_en)
      mem_q[wp_q] <= wr_data_in;
  end
  always @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      wp_q         <= {AW{1'b0}};
      rp_q         <= {AW{1'b0}};
      cnt_q        <= {(AW+1){1'b0}};
      rd_valid_out <= 1'b0;
      rd_data_out  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (wr_en)
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      if (rd_en)
      begin
        rd_data_out  <= mem_q[rp_q];
        rp_q         <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
        rd_valid_out <= 1'b1;
      end
      else if (rd_ready_in)
        rd_valid_out <= 1'b0;
      cnt_q <= cnt_q + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
    end
  end
endmodule // slr_fifo

// ---- verif/slr_pacer_asserts.sv ----
// assertions on the line pacer ports
module slr_pacer_asserts #(
  parameter GAP_CYC = 200
) (
  input wire logic       clk_sys_in,
  input wire logic       sys_rst_in,
  input wire logic       frame_start_in,
  input wire logic       large_variant_in,
  input wire logic       colour_in,
  input wire logic       row_gap_en_in,
  input wire logic [7:0] pix_div_in,
  input wire logic       pix_valid_out,
  input wire logic       pix_clk_en_out,
  input wire logic       line_valid_out,
  input wire logic [1:0] bayer_phase_out,
  input wire logic       exposure_on_out,
  input wire logic [6:0] col_group_out,
  input wire logic       order_err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic [15:0] idle_q;
  // starts saturated so the first line after reset owes no gap
  always @(posedge clk_sys_in)
    if (sys_rst_in)
      idle_q <= 16'hFFFF;
    else if (line_valid_out)
      idle_q <= 16'h0000;
    else if (idle_q != 16'hFFFF)
      idle_q <= idle_q + 16'h0001;
  property p_paced; pix_valid_out |-> pix_clk_en_out; endproperty
  a_paced: assert property (p_paced) else $error("pixel off the pace");
  property p_in_line; pix_valid_out |-> line_valid_out; endproperty
  a_in_line: assert property (p_in_line) else $error("pixel outside line");
  property p_div; pix_clk_en_out && pix_div_in != 8'h00 && $stable(pix_div_in) |=> !pix_clk_en_out; endproperty
  a_div: assert property (p_div) else $error("pace too fast");
  property p_mono; !colour_in && pix_valid_out |=> bayer_phase_out == 2'h0; endproperty
  a_mono: assert property (p_mono) else $error("mosaic on mono");
  property p_group; 1 |=> col_group_out == ($past(large_variant_in) ? 7'h50 : 7'h40); endproperty
  a_group: assert property (p_group) else $error("wrong column group");
  property p_exp; frame_start_in |=> !exposure_on_out; endproperty
  a_exp: assert property (p_exp) else $error("exposure kept on");
  property p_err; frame_start_in |=> !order_err_out; endproperty
  a_err: assert property (p_err) else $error("order flag kept");
  property p_gap; $rose(line_valid_out) && row_gap_en_in |-> idle_q >= GAP_CYC; endproperty
  a_gap: assert property (p_gap) else $error("line gap too short");
endmodule // slr_pacer_asserts

// ---- verif/slr_grabber_model.sv ----
// frame grabber model: keeps the flagged pixels of each line
module slr_grabber_model (
  input wire logic       clk_sys_in,
  input wire logic [9:0] pix_data_in,
  input wire logic       pix_valid_in,
  input wire logic       line_valid_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] pix_q[$];
  int         lines = 0;
  logic       lv_q = 1'b0;
  // idle and gap cycles are simply skipped, at any pixel rate
  always @(posedge clk_sys_in)
  begin
    if (pix_valid_in && line_valid_in)
      pix_q.push_back(pix_data_in);
    if (!line_valid_in && lv_q)
      lines++;
    lv_q <= line_valid_in;
  end
endmodule // slr_grabber_model

// ---- verif/slr_line_pacer_tb.sv ----
// self-checking bench for the line pacer
module slr_line_pacer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam GAP = 20;
  logic         clk_sys_in = 0, sys_rst_in = 1, row_start_in = 0, frame_start_in = 0;
  logic         large_variant_in = 0, colour_in = 0, row_gap_en_in = 0, exp_armed_in = 0;
  logic [319:0] lane_data_in = '0;
  logic [31:0]  lane_valid_in = '0;
  logic [15:0]  row_index_in = 0, row_width_in = 1, rows_per_frame_in = 1;
  logic [7:0]   pix_div_in = 0;
  wire          lane_ready_out, pix_valid_out, pix_clk_en_out, line_valid_out, frame_valid_out;
  wire          exposure_on_out, adc_strobe_out, order_err_out;
  wire  [9:0]   pix_data_out;
  wire  [1:0]   bayer_phase_out;
  wire  [6:0]   col_group_out;
  int           num_errors = 0, tests_run = 0, strobes = 0, acc = 0, seed = 32'h9909;
  logic [15:0]  bcol = 0, bline = 0;
  logic         lv_q = 0;
  logic [9:0]   exp_q[$];
  slr_line_pacer #(.GAP_CYC(GAP)) i_dut (.clk_sys_in, .sys_rst_in, .lane_data_in, .lane_valid_in,
    .row_start_in, .row_index_in, .frame_start_in, .row_width_in, .rows_per_frame_in,
    .large_variant_in, .colour_in, .row_gap_en_in, .pix_div_in, .exp_armed_in, .lane_ready_out,
    .pix_data_out, .pix_valid_out, .pix_clk_en_out, .line_valid_out, .frame_valid_out,
    .bayer_phase_out, .exposure_on_out, .adc_strobe_out, .col_group_out, .order_err_out);
  slr_grabber_model i_grab (.clk_sys_in, .pix_data_in(pix_data_out), .pix_valid_in(pix_valid_out),
    .line_valid_in(line_valid_out));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (adc_strobe_out) strobes++;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // mosaic position counted by the bench: column within line, line within frame
  always @(posedge clk_sys_in)
  begin
    lv_q <= line_valid_out;
    if (pix_valid_out === 1'b1)
    begin
      chk(16'(bayer_phase_out), colour_in ? {14'h0, bline[0], bcol[0]} : 16'h0, "bayer phase");
      bcol <= bcol + 16'h1;
    end
    if (lv_q && line_valid_out === 1'b0)
    begin
      bcol <= 16'h0;
      bline <= bline + 16'h1;
    end
    if (frame_start_in)
    begin
      bcol <= 16'h0;
      bline <= 16'h0;
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic bound(inout int g);
    if (++g > 20000)
    begin
      chk(16'h0, 16'h1, "wait ran out");
      test_done();
    end
  endtask
  // one write every other cycle, only while the fifo shows room, since ready lags a cycle
  task automatic send_row(input int idx, input int w, input bit keep);
    int l, g;
    logic [9:0] v;
    g = 0;
    @(negedge clk_sys_in) row_start_in = 1;
    row_index_in = idx[15:0];
    @(negedge clk_sys_in) row_start_in = 0;
    for (int p = 0; p < w; bound(g))
    begin
      if (lane_ready_out === 1'b1)
      begin
        l = {$random(seed)} % 32;
        v = $random(seed);
        lane_data_in = {10{$random(seed)}};
        lane_data_in[l*10 +: 10] = v;
        lane_valid_in = $random(seed) & (32'hFFFFFFFF << l) | (32'h1 << l);
        if (keep)
          exp_q.push_back(v);
        acc += keep;
        p++;
      end
      @(negedge clk_sys_in) lane_valid_in = 0;
      @(negedge clk_sys_in);
    end
  endtask
  task automatic frame(input int rows, input int w, input bit skip);
    int n0, g;
    n0 = i_grab.lines;
    g = 0;
    row_width_in = w[15:0];
    rows_per_frame_in = rows[15:0];
    @(negedge clk_sys_in) frame_start_in = 1;
    @(negedge clk_sys_in) frame_start_in = 0;
    chk(exposure_on_out, 1'b0, "exposure not cleared");
    chk(order_err_out, 1'b0, "order flag not cleared");
    for (int r = 0; r < rows; r++)
    begin
      exp_armed_in = (r == 0);
      send_row(r, w, 1);
      if (skip && r == 0)
        send_row(r + 2, w, 0);
    end
    if (skip)
      chk(order_err_out, 1'b1, "skipped row taken");
    chk(exposure_on_out, 1'b1, "no overlapping exposure");
    while (i_grab.pix_q.size() < exp_q.size() || line_valid_out !== 1'b0)
      @(negedge clk_sys_in) bound(g);
    repeat (GAP + 4) @(negedge clk_sys_in);
    while (exp_q.size())
      chk(i_grab.pix_q.pop_front(), exp_q.pop_front(), "pixel value or order");
    chk(16'(i_grab.pix_q.size()), 16'h0, "dropped row leaked");
    chk(16'(i_grab.lines - n0), rows[15:0], "line count");
    chk(col_group_out, large_variant_in ? 16'h50 : 16'h40, "column group");
  endtask
  initial
  begin
    repeat (5) @(negedge clk_sys_in);
    sys_rst_in = 0;
    for (int f = 0; f < 6; f++)
    begin
      large_variant_in = $random(seed);
      colour_in = $random(seed);
      row_gap_en_in = (f != 0);
      pix_div_in = (f == 1) ? 8'h07 : 8'({$random(seed)} % 4);
      frame((f == 0) ? 1 : 2 + f % 2, (f == 1) ? 40 : (f == 0 ? 1 : 1 + {$random(seed)} % 24), f == 2);
      $display("frame test %0d done", f);
    end
    chk(16'(strobes), 16'((acc + 63) / 64), "converter strobe count");
    test_done();
  end
endmodule // slr_line_pacer_tb
bind slr_line_pacer slr_pacer_asserts #(.GAP_CYC(GAP_CYC)) i_chk (.clk_sys_in, .sys_rst_in, .frame_start_in,
  .large_variant_in, .colour_in, .row_gap_en_in, .pix_div_in, .pix_valid_out, .pix_clk_en_out,
  .line_valid_out, .bayer_phase_out, .exposure_on_out, .col_group_out, .order_err_out);
